// >>> hw/dacimx_core.sv
// DAC digital front end: word mux, blanking, latches, encoder, bus slave
//
// Function
// - Word select high passes the primary word, low the secondary.
// - Blank request low leaves the selected word alone steering switches.
// - Blank request high forces all data bits and blank bit high.
// - Blank request is sampled only while word select is high.
// - Falling word select captures blank state and holds it until high.
// - Select held low keeps a captured blank forever.
// - Data inputs are complemented; larger value drives output negative.
// - Eight data bits and blank bit register in a nine-bit master.
// - Top three master bits become a seven-line thermometer code.
// - Five low bits and blank bit pass unencoded, only delayed.
// - Thermometer lines and six delayed bits re-register in slave.
// - Slave updates on each conversion edge, moving the output.
// - Each thermometer line steers one eighth of full scale.
// - Five low bits steer binary weights from one sixteenth downward.
// - Blank bit steers a separate current of about 10.4 percent.
module dacimx_core
    import dacimx_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Converter pins; data words in complemented polarity, select and blank true-high
    input wire logic [DATA_W-1:0] word_a_n,
    input wire logic [DATA_W-1:0] word_b_n,
    input wire logic word_select,
    input wire logic blank_req,
    // Switch controls and summed level
    output dacimx_switch_t switch_ff,
    output logic [LVL_W-1:0] level_ff,
    output logic [9:0] blank_permille,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dacimx_pins_t pins_meta_ff;
    dacimx_pins_t pins_sync_ff;
    dacimx_pins_t pins_raw;
    dacimx_master_t master_ff;
    dacimx_master_t nxt_master;
    dacimx_switch_t nxt_switch;
    logic blank_hold_ff;
    logic blank_eff;
    logic [DATA_W-1:0] code_a;
    logic [DATA_W-1:0] code_b;
    logic [DATA_W-1:0] code_sel;
    logic [SEG_N-1:0] therm;
    logic [7:0] div_cnt_ff;
    logic [7:0] div_val;
    logic conv_en;
    logic tick;
    logic [31:0] ctrl_ff;
    logic [31:0] count_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic bvalid_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic aw_take;
    logic w_take;
    logic wr_do;
    logic ar_take;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] ctrl_wmask;
    logic [31:0] nxt_ctrl;
    logic wr_ctrl;
    logic wr_hit;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic rd_hit;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pins_raw = '{word_select: word_select, blank_req: blank_req,
                        word_a_n: word_a_n, word_b_n: word_b_n};

    // Two flip-flops on every pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_meta_ff <= '0;
            pins_sync_ff <= '0;
        end else begin
            pins_meta_ff <= pins_raw;
            pins_sync_ff <= pins_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Conversion rate divider
    // ------------------------------------------------------------
    assign div_val = ctrl_ff[CTRL_DIV_LSB +: 8];
    assign conv_en = ctrl_ff[CTRL_EN_BIT];
    assign tick = conv_en && (div_cnt_ff >= div_val);

    // Counts aclk cycles between conversion edges
    always_ff @(posedge aclk) begin
        if (!aresetn || !conv_en || tick) begin
            div_cnt_ff <= '0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Word multiplexer and blanking logic
    // ------------------------------------------------------------
    assign code_a = ~pins_sync_ff.word_a_n;
    assign code_b = ~pins_sync_ff.word_b_n;
    assign code_sel = pins_sync_ff.word_select ? code_a : code_b;
    // Blank follows the pin only with the primary word selected
    assign blank_eff = pins_sync_ff.word_select ? pins_sync_ff.blank_req
                                                : blank_hold_ff;
    // Blank forces every bit high, otherwise data pass untouched
    assign nxt_master = '{blank: blank_eff,
                          data: code_sel | {DATA_W{blank_eff}}};

    // Held blank state is refreshed only while primary is selected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blank_hold_ff <= 1'b0;
        end else if (tick) begin
            blank_hold_ff <= blank_eff;
        end
    end

    // Nine-bit master latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_ff <= '0;
        end else if (tick) begin
            master_ff <= nxt_master;
        end
    end

    // ------------------------------------------------------------
    // Encoder and slave latch
    // ------------------------------------------------------------
    dacimx_thermo u_thermo (
        .bin(master_ff.data[DATA_W-1 -: MSB_N]),
        .therm(therm)
    );

    assign nxt_switch = '{blank: master_ff.blank, seg: therm,
                          bits: master_ff.data[BIT_N-1:0]};

    // Slave latch updates on the next conversion edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switch_ff <= '0;
        end else if (tick) begin
            switch_ff <= nxt_switch;
        end
    end

    // Weighted current level of the switch controls
    dacimx_weight u_weight (
        .aclk(aclk),
        .aresetn(aresetn),
        .sw(switch_ff),
        .level_ff(level_ff)
    );

    assign blank_permille = BLANK_PERMILLE;

    // Conversion counter for software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= '0;
        end else if (tick) begin
            count_ff <= count_ff + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_do = (aw_take || aw_got_ff) && (w_take || w_got_ff);
    assign wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_ctrl = wr_do && (wr_addr == ADDR_CTRL);
    assign wr_hit = wr_ctrl || (wr_addr == ADDR_STATUS)
        || (wr_addr == ADDR_COUNT);
    assign ctrl_wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                         {8{wr_strb[1]}}, {8{wr_strb[0]}}} & CTRL_MASK;
    assign nxt_ctrl = (ctrl_ff & ~ctrl_wmask) | (wr_data & ctrl_wmask);

    // Address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_do) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
        end else begin
            aw_got_ff <= aw_got_ff || aw_take;
            w_got_ff <= w_got_ff || w_take;
        end
    end

    // Captured write payload
    always_ff @(posedge aclk) begin
        if (aw_take) begin
            awaddr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
    end

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Write response, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    assign status_word = {18'h0, blank_hold_ff, switch_ff};
    assign s_axi_arready = !rvalid_ff;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_hit = (s_axi_araddr == ADDR_CTRL)
        || (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_COUNT);
    assign rd_word = (s_axi_araddr == ADDR_CTRL) ? ctrl_ff
        : (s_axi_araddr == ADDR_STATUS) ? status_word
        : (s_axi_araddr == ADDR_COUNT) ? count_ff : 32'h0000_0000;

    // Read data, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Reset is in the antecedent too: on the edge that releases reset the
    // latches are still being cleared, so no load can be expected there
    mux_primary_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && tick && pins_sync_ff.word_select && !blank_eff
        |=> master_ff.data == ~$past(pins_sync_ff.word_a_n))
        else $error("primary word not latched");

    mux_secondary_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && tick && !pins_sync_ff.word_select && !blank_eff
        |=> master_ff.data == ~$past(pins_sync_ff.word_b_n))
        else $error("secondary word not latched");

    blank_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && tick && pins_sync_ff.word_select && pins_sync_ff.blank_req
        |=> master_ff == 9'h1FF)
        else $error("blank did not force all bits high");

    blank_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !pins_sync_ff.word_select ##1 !pins_sync_ff.word_select
        |-> $stable(blank_hold_ff))
        else $error("held blank changed while secondary selected");

    blank_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !pins_sync_ff.word_select && blank_hold_ff
        |=> master_ff.blank)
        else $error("captured blank was lost");

    thermo_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |=> $countones(switch_ff.seg)
            == $past(master_ff.data[DATA_W-1 -: MSB_N]))
        else $error("thermometer count wrong");

    low_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |=> switch_ff.bits == $past(master_ff.data[BIT_N-1:0])
            && switch_ff.blank == $past(master_ff.blank))
        else $error("low bits not delayed into slave");

    slave_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !tick |=> $stable(switch_ff))
        else $error("slave changed without conversion edge");

    level_sum_a: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> level_ff == LVL_W'($countones($past(switch_ff.seg))
            * SEG_WEIGHT + $past(switch_ff.bits)))
        else $error("weighted level wrong");

    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule : dacimx_core

// >>> hw/dacimx_pkg.sv
// Package with constants and carrier types for the DAC input front end
package dacimx_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned SEG_N = 7;
    localparam int unsigned BIT_N = 5;
    localparam int unsigned MSB_N = 3;
    localparam int unsigned LVL_W = 8;
    localparam int unsigned PIN_W = 2 * DATA_W + 2;

    // ------------------------------------------------------------
    // Current weights in units of 1/256 of full scale
    // ------------------------------------------------------------
    localparam logic [LVL_W-1:0] SEG_WEIGHT = 8'h20;
    // Blanking current in tenths of a percent of full scale
    localparam logic [9:0] BLANK_PERMILLE = 10'h068;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_DIV_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] CTRL_MASK = 32'h0000_FF01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic blank;
        logic [DATA_W-1:0] data;
    } dacimx_master_t;

    typedef struct packed {
        logic blank;
        logic [SEG_N-1:0] seg;
        logic [BIT_N-1:0] bits;
    } dacimx_switch_t;

    typedef struct packed {
        logic word_select;
        logic blank_req;
        logic [DATA_W-1:0] word_a_n;
        logic [DATA_W-1:0] word_b_n;
    } dacimx_pins_t;
endpackage : dacimx_pkg

// >>> hw/dacimx_thermo.sv
// Binary to seven-line thermometer encoder
module dacimx_thermo
    import dacimx_pkg::*;
(
    // Binary code
    input wire logic [MSB_N-1:0] bin,
    // Thermometer lines
    output logic [SEG_N-1:0] therm
);
    // ------------------------------------------------------------
    // Line i is set when the code exceeds i, filling from line 0
    // ------------------------------------------------------------
    for (genvar i = 0; i < SEG_N; i++) begin : g_line
        assign therm[i] = ({1'b0, bin} > 4'(i));
    end
endmodule : dacimx_thermo

// >>> hw/dacimx_weight.sv
// Weighted current sum of the switch controls
module dacimx_weight
    import dacimx_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Switch controls
    input wire dacimx_switch_t sw,
    // Summed level in 1/256 of full scale, blanking excluded
    output logic [LVL_W-1:0] level_ff
);
    logic [LVL_W-1:0] nxt_level;
    logic [2:0] seg_cnt;

    // ------------------------------------------------------------
    // Each segment is 1/8, bits weigh 1/16 down to lower powers
    // ------------------------------------------------------------
    assign seg_cnt = 3'($countones(sw.seg));
    assign nxt_level = LVL_W'(seg_cnt * SEG_WEIGHT)
        + LVL_W'(sw.bits);

    // Registered level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_ff <= '0;
        end else begin
            level_ff <= nxt_level;
        end
    end
endmodule : dacimx_weight

// >>> bench/dacimx_src_model.sv
// Behavioural model of the logic source that feeds the converter pins
module dacimx_src_model
    import dacimx_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Commands from the bench
    input wire logic [DATA_W-1:0] code_a,
    input wire logic [DATA_W-1:0] code_b,
    input wire logic sel,
    input wire logic mux,
    input wire logic blank,
    // Converter pins
    output dacimx_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Pins start quiet so the select toggle has a known phase
    initial begin
        pins = '0;
    end

    // Codes leave complemented; select toggles every cycle in mux mode
    always @(posedge aclk) begin
        pins.word_a_n <= ~code_a;
        pins.word_b_n <= ~code_b;
        pins.blank_req <= blank;
        if (mux) begin
            pins.word_select <= ~pins.word_select;
        end else begin
            pins.word_select <= sel;
        end
    end
endmodule : dacimx_src_model

// >>> bench/tb_top.sv
// Self-checking bench for the converter front end
module tb_top
    import dacimx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk, aresetn, sel, mux, blank;
    logic [7:0] code_a, code_b, awaddr, araddr, c;
    dacimx_pins_t pins;
    dacimx_switch_t sw;
    logic [LVL_W-1:0] level;
    logic [9:0] bpm;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, rs;
    int fail_count, n_tests, seen_a, seen_b;
    logic [7:0] corners [4] = '{8'h00, 8'hFF, 8'h20, 8'hDF};

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    dacimx_src_model src (.aclk(aclk), .code_a(code_a), .code_b(code_b),
        .sel(sel), .mux(mux), .blank(blank), .pins(pins));

    dacimx_core dut (.aclk(aclk), .aresetn(aresetn),
        .word_a_n(pins.word_a_n), .word_b_n(pins.word_b_n),
        .word_select(pins.word_select), .blank_req(pins.blank_req),
        .switch_ff(sw), .level_ff(level), .blank_permille(bpm),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // Free-running 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Switch controls expected for a code, blanking forcing all ones
    function automatic logic [12:0] exp_sw(input logic [7:0] code,
                                           input logic blk);
        logic [7:0] d;
        d = blk ? 8'hFF : code;
        exp_sw = {blk, 7'((8'h01 << d[7:5]) - 8'h01), d[4:0]};
    endfunction : exp_sw

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("Checks: %0d, mismatches: %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Hold the source steady long enough for the latch pipeline
    task automatic drive(input logic [7:0] a, input logic [7:0] b,
                         input logic s, input logic bl, input int n);
        code_a <= a;
        code_b <= b;
        sel <= s;
        blank <= bl;
        repeat (n) @(posedge aclk);
    endtask : drive

    // Level equals the forced or passed code: 32 per segment plus bits
    task automatic check_out(input logic [7:0] code, input logic blk);
        check("switch", 32'(sw), 32'(exp_sw(code, blk)));
        check("level", 32'(level), blk ? 32'hFF : 32'(code));
    endtask : check_out

    // Write with address and data offered together, each released on take
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        // Let an edge pass so a following call never reassigns bready
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        // Let an edge pass so a following call never reassigns rready
        @(posedge aclk);
    endtask : axi_read

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // Whole run needs a few hundred cycles; the 10,000-cycle limit cuts a hang short
    initial begin
        #(100_000);
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        n_tests = 0;
        {aresetn, sel, mux, blank, code_a, code_b} = '0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready} = '0;
        wstrb = 4'hF;
        void'($urandom(32'h8496));
        repeat (12) @(posedge aclk);
        check("switch_rst", 32'(sw), 32'h0);
        check("level_rst", 32'(level), 32'h0);
        aresetn <= 1'b1;
        sel <= 1'b1;
        axi_read(ADDR_CTRL, rd, rs);
        check("ctrl_rst", rd, CTRL_RESET);
        check("blank_cur", 32'(bpm), 32'h68);
        // Corner and random codes on the primary word, complemented pins
        for (int i = 0; i < 12; i++) begin
            c = (i < 4) ? corners[i] : 8'($urandom);
            drive(c, ~c, 1'b1, 1'b0, 10);
            check_out(c, 1'b0);
        end
        drive(8'h5A, 8'hC3, 1'b0, 1'b0, 10);
        check_out(8'hC3, 1'b0);
        // Blanking, then holding it while the secondary word is selected
        drive(8'h12, 8'h34, 1'b1, 1'b1, 10);
        check_out(8'h12, 1'b1);
        axi_read(ADDR_STATUS, rd, rs);
        check("status", rd, {18'h0, 1'b1, exp_sw(8'h12, 1'b1)});
        drive(8'h12, 8'h34, 1'b0, 1'b0, 40);
        check_out(8'h34, 1'b1);
        drive(8'h12, 8'h34, 1'b1, 1'b0, 10);
        check_out(8'h12, 1'b0);
        // Request raised only while the secondary word is selected
        drive(8'h40, 8'h41, 1'b0, 1'b0, 10);
        drive(8'h40, 8'h41, 1'b0, 1'b1, 20);
        check_out(8'h41, 1'b0);
        drive(8'h40, 8'h41, 1'b1, 1'b0, 10);
        check_out(8'h40, 1'b0);
        // Conversion stops when disabled, slows with the divider
        axi_write(ADDR_CTRL, 32'h0, 4'hF, rs);
        drive(8'h77, 8'h00, 1'b1, 1'b0, 20);
        check_out(8'h40, 1'b0);
        axi_write(ADDR_CTRL, 32'h0000_0301, 4'hF, rs);
        drive(8'h77, 8'h00, 1'b1, 1'b0, 40);
        check_out(8'h77, 1'b0);
        // Byte strobes keep the divider byte unchanged
        axi_write(ADDR_CTRL, 32'hFFFF_0001, 4'h1, rs);
        axi_read(ADDR_CTRL, rd, rs);
        check("ctrl_strb", rd, 32'h0000_0301);
        axi_write(ADDR_CTRL, CTRL_RESET, 4'hF, rs);
        axi_write(ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, rs);
        check("status_wr", 32'(rs), 32'(RESP_OKAY));
        axi_write(8'h0C, 32'h1, 4'hF, rs);
        check("unmapped_wr", 32'(rs), 32'(RESP_SLVERR));
        axi_read(8'h0C, rd, rs);
        check("unmapped_rd", {rd[29:0], rs}, 32'(RESP_SLVERR));
        // Multiplexed half-rate words alternate on the output
        drive(8'h81, 8'h3C, 1'b1, 1'b0, 2);
        mux <= 1'b1;
        repeat (12) @(posedge aclk);
        seen_a = 0;
        seen_b = 0;
        repeat (12) begin
            @(posedge aclk);
            if (sw === exp_sw(8'h81, 1'b0)) seen_a++;
            else if (sw === exp_sw(8'h3C, 1'b0)) seen_b++;
        end
        check("mux_a", 32'(seen_a), 32'h6);
        check("mux_b", 32'(seen_b), 32'h6);
        end_of_test();
    end
endmodule : tb_top
